// ==== dv/sbpl_host.sv ====
module sbpl_host
   import sbpl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   input wire logic holdOff
);
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // byte collector
   // -------------------------------------------------------------
   logic [7:0] got[$];
   int pktLeft;

   // a stall simply withholds ready; the loader must keep its byte
   assign txReady = !holdOff;

   always @(posedge core_clk) begin
      if (!rstn) begin
         got.delete();
         pktLeft = 0;
      end else if (txValid === 1'b1 && txReady) begin
         if (pktLeft > 0) begin
            got.push_back(txData);
            pktLeft--;
         end else if (txData !== ZERO_BYTE) begin
            got.push_back(txData);
            if (txData !== ACK_BYTE && txData !== NAK_BYTE) begin
               pktLeft = int'(txData) - 1;
            end
         end
      end
   end
endmodule

// ==== dv/testbench.sv ====
module testbench
   import sbpl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic aValid = 1'b0;
   logic bValid = 1'b0;
   logic flashDone = 1'b0;
   logic holdOff = 1'b0;
   logic useA = 1'b0;
   logic flashErr = 1'b0;
   logic failNext = 1'b0;
   logic [7:0] hostRep = ACK_BYTE;
   logic [7:0] aData = 8'h00;
   logic [7:0] bData = 8'h00;
   logic txValid, txReady, txOnB, flashEraseReq, flashWrReq, runReq, swResetReq;
   logic [7:0] txData, flashWrData;
   logic [31:0] flashAddr, flashSize, runAddr, ersA, ersS;
   logic [31:0] wrA[$];
   logic [7:0] wrD[$];
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int fdCnt = 0;
   int ersCnt = 0;
   int runCnt = 0;
   int rstCnt = 0;

   always #4 core_clk = ~core_clk;

   sbpl_loader u_sbpl_loader (.core_clk(core_clk), .rstn(rstn), .clkEn(1'b1),
      .aValid(aValid), .aData(aData), .bValid(bValid), .bData(bData),
      .txValid(txValid), .txData(txData), .txReady(txReady), .txOnB(txOnB),
      .flashEraseReq(flashEraseReq), .flashWrReq(flashWrReq), .flashAddr(flashAddr),
      .flashSize(flashSize), .flashWrData(flashWrData), .flashDone(flashDone),
      .flashErr(flashErr), .runReq(runReq), .runAddr(runAddr), .swResetReq(swResetReq));

   sbpl_host u_sbpl_host (.core_clk(core_clk), .rstn(rstn), .txValid(txValid),
      .txData(txData), .txReady(txReady), .holdOff(holdOff));

   // -------------------------------------------------------------
   // flash responder and watchdog
   // -------------------------------------------------------------
   // a slow flash (done six cycles late) keeps erase ordering visible
   always @(negedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         finish_test();
      end
      if (flashEraseReq === 1'b1 || flashWrReq === 1'b1) begin
         fdCnt = 6;
         flashDone <= 1'b0;
         flashErr <= 1'b0;
      end else begin
         flashDone <= (fdCnt == 1);
         flashErr <= (fdCnt == 1) && failNext;
         if (fdCnt > 0) fdCnt--;
      end
      if (flashWrReq === 1'b1) begin
         wrA.push_back(flashAddr);
         wrD.push_back(flashWrData);
      end
      if (flashEraseReq === 1'b1) begin
         ersCnt++;
         ersA = flashAddr;
         ersS = flashSize;
      end
      if (runReq === 1'b1) runCnt++;
      if (swResetReq === 1'b1) rstCnt++;
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic finish_test();
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic doReset();
      @(negedge core_clk);
      rstn = 1'b0;
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
   endtask

   task automatic sendByte(input logic [7:0] b);
      @(negedge core_clk);
      aValid = useA;
      bValid = !useA;
      aData = b;
      bData = b;
      @(negedge core_clk);
      aValid = 1'b0;
      bValid = 1'b0;
   endtask

   // sumAdj nonzero corrupts the checksum on purpose
   task automatic sendPkt(input logic [7:0] p[$], input logic [7:0] sumAdj);
      logic [7:0] s;
      s = sumAdj;
      repeat (4) @(negedge core_clk);
      foreach (p[i]) s += p[i];
      sendByte(8'(p.size() + 2));
      sendByte(s);
      foreach (p[i]) sendByte(p[i]);
   endtask

   task automatic expByte(input string what, input logic [7:0] exp);
      int n;
      n = 0;
      while (u_sbpl_host.got.size() == 0 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      if (u_sbpl_host.got.size() == 0) chk(what, 32'(exp), 'x);
      else chk(what, 32'(exp), 32'(u_sbpl_host.got.pop_front()));
   endtask

   task automatic getStatus(input logic [7:0] st, input int stall);
      holdOff = (stall > 0);
      sendPkt('{CMD_STATUS}, 8'h00);
      repeat (stall) @(negedge core_clk);
      if (stall > 0) chk("stalled valid", 32'h1, 32'(txValid));
      holdOff = 1'b0;
      expByte("status ack", ACK_BYTE);
      expByte("status len", RESP_LEN);
      expByte("status sum", st);
      expByte("status code", st);
      sendByte(ZERO_BYTE);
      sendByte(hostRep);
   endtask

   task automatic sendData(input logic [7:0] p[$], input logic [7:0] exp);
      sendPkt(p, exp == NAK_BYTE ? 8'h01 : 8'h00);
      expByte("data ack", exp);
      repeat (60) @(negedge core_clk);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_sync();
      useA = 1'b1;
      sendByte(SYNC_BYTE);
      sendByte(SYNC_BYTE);
      expByte("sync ack", ACK_BYTE);
      chk("reply link", 32'h0, 32'(txOnB));
      useA = 1'b0;
      sendPkt('{CMD_PING}, 8'h00);
      repeat (30) @(negedge core_clk);
      chk("other link ignored", 32'h0, 32'(u_sbpl_host.got.size()));
   endtask

   task automatic t_ping();
      sendByte(ZERO_BYTE);
      sendPkt('{CMD_PING}, 8'h00);
      expByte("ping ack", ACK_BYTE);
      chk("reply link", 32'h1, 32'(txOnB));
      hostRep = NAK_BYTE;
      getStatus(STAT_SUCCESS, 0);
      hostRep = ACK_BYTE;
      getStatus(STAT_SUCCESS, 0);
   endtask

   task automatic t_frames();
      sendPkt('{8'h30}, 8'h01);
      expByte("bad sum nak", NAK_BYTE);
      getStatus(STAT_SUCCESS, 0);
      sendPkt('{8'h30}, 8'h00);
      expByte("unknown ack", ACK_BYTE);
      getStatus(STAT_UNKNOWN, 40);
      sendData('{CMD_SEND, 8'hAA}, ACK_BYTE);
      chk("orphan writes", 32'h0, 32'(wrA.size()));
      getStatus(STAT_INVALID, 0);
   endtask

   task automatic t_download();
      logic [7:0] expD[$];
      logic [7:0] dlPkt[$];
      expD = '{8'hF0, 8'h80, 8'h7F, 8'h11, 8'h22};
      dlPkt = '{CMD_DOWNLOAD, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
      sendPkt(dlPkt, 8'h00);
      expByte("download ack", ACK_BYTE);
      chk("erase before ack", 32'h1, 32'(ersCnt));
      chk("erase addr", 32'h0000_1F00, ersA);
      chk("erase size", 32'h0000_0005, ersS);
      getStatus(STAT_SUCCESS, 0);
      sendData('{CMD_SEND, 8'hF0, 8'h80, 8'h7F}, ACK_BYTE);
      sendData('{CMD_SEND, 8'h55, 8'h66}, NAK_BYTE);
      chk("addr after nak", 32'h0000_1F03, flashAddr);
      sendData('{CMD_SEND, 8'h11, 8'h22, 8'h33}, ACK_BYTE);
      chk("write count", 32'h5, 32'(wrA.size()));
      foreach (expD[i]) begin
         chk("write addr", 32'h0000_1F00 + 32'(i), wrA[i]);
         chk("write data", 32'(expD[i]), 32'(wrD[i]));
      end
      // a failed erase reports flash failure and leaves no session open
      failNext = 1'b1;
      sendPkt(dlPkt, 8'h00);
      expByte("failed erase ack", ACK_BYTE);
      failNext = 1'b0;
      getStatus(STAT_FLASH_FAIL, 0);
      sendData('{CMD_SEND, 8'h44}, ACK_BYTE);
      getStatus(STAT_INVALID, 0);
      chk("writes after failed erase", 32'h5, 32'(wrA.size()));
   endtask

   task automatic t_run();
      sendPkt('{CMD_RUN, 8'h00, 8'h00, 8'h12, 8'h34}, 8'h00);
      expByte("run ack", ACK_BYTE);
      repeat (20) @(negedge core_clk);
      chk("run pulses", 32'h1, 32'(runCnt));
      chk("run addr", 32'h0000_1234, runAddr);
      sendPkt('{CMD_RESET}, 8'h00);
      expByte("reset ack", ACK_BYTE);
      repeat (20) @(negedge core_clk);
      chk("reset pulses", 32'h1, 32'(rstCnt));
   endtask

   initial begin
      doReset();
      t_sync();
      doReset();
      t_ping();
      t_frames();
      t_download();
      t_run();
      finish_test();
   end
endmodule

// ==== hw/sbpl_loader.sv ====
// How it works
// (R1) packets open with a length byte counting length, checksum and payload
// (R2) second byte is the sum of payload bytes only
// (R3) intact packet answered 0xCC, failed packet answered 0x33
// (R4) acknowledge reflects framing and checksum only, not command validity
// (R5) zero bytes may precede a response; host skips them
// (R6) response bytes follow back to back once the first is sent
// (R7) host answers every device packet with acknowledge or negative one
// (R8) host reissues the command after rejecting a device packet
// (R9) zeros are skipped while waiting for the host's reply byte
// (R10) first payload byte is the command code, then its parameters
// (R11) ping 0x20 of length 3 sets status success, acknowledge only
// (R12) status query 0x23 returns one-byte packet holding last status
// (R13) download 0x21, 11 bytes, carries address then size, MSB first
// (R14) download erases the area before acknowledging; status shows validity
// (R15) data write 0x24 programs at current address, then advances it
// (R16) host sends at most eight data bytes per data write
// (R17) session ends when announced byte count has been programmed
// (R18) a rejected data write leaves the programming address unchanged
// (R19) host sends data writes only after download or data write
// (R20) run 0x22, 7 bytes, acknowledged before jumping to the address
// (R21) reset 0x25 acknowledged first, then a software system reset
// (R22) host should query status after each command
// (R23) two 0x55 bytes on the async link are answered with 0xCC
// (R24) once one link talks, the other is ignored until reset
// (R25) checksum is an 8-bit wrapping sum compared with the received byte
// (R26) unknown command or orphan data write is acknowledged, status failure
module sbpl_loader
   import sbpl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic aValid,
   input wire logic [7:0] aData,
   input wire logic bValid,
   input wire logic [7:0] bData,
   output logic txValid,
   output logic [7:0] txData,
   input wire logic txReady,
   output logic txOnB,
   output logic flashEraseReq,
   output logic flashWrReq,
   output logic [31:0] flashAddr,
   output logic [31:0] flashSize,
   output logic [7:0] flashWrData,
   input wire logic flashDone,
   input wire logic flashErr,
   output logic runReq,
   output logic [31:0] runAddr,
   output logic swResetReq
);

   // ---------------------------------------------------------------
   // state and decode helpers
   // ---------------------------------------------------------------
   sbpl_core_t q;
   sbpl_core_t d;
   logic bufReady;
   logic rxV;
   logic [7:0] rxB;
   logic [7:0] cmd;
   logic [31:0] pAddr;
   logic [31:0] pSize;
   logic [32:0] dlEnd;
   logic dlOk;

   // only the locked link is heard from here on
   assign rxV = q.locked && (q.onB ? bValid : aValid); // R24
   assign rxB = q.onB ? bData : aData;
   assign cmd = q.pay[PAY_CMD]; // R10
   assign pAddr = {q.pay[PAY_ADDR], q.pay[PAY_ADDR + 4'h1],
                   q.pay[PAY_ADDR + 4'h2], q.pay[PAY_ADDR + 4'h3]}; // R13
   assign pSize = {q.pay[PAY_SIZE], q.pay[PAY_SIZE + 4'h1],
                   q.pay[PAY_SIZE + 4'h2], q.pay[PAY_SIZE + 4'h3]}; // R13
   assign dlEnd = {1'b0, pAddr} + {1'b0, pSize};
   assign dlOk = (pSize != 32'h0000_0000) && (dlEnd <= FLASH_BYTES); // R14

   assign txOnB = q.onB;
   assign flashEraseReq = q.flashEraseReq;
   assign flashWrReq = q.flashWrReq;
   assign flashAddr = q.addr;
   assign flashSize = q.remain;
   assign flashWrData = q.flashWrData;
   assign runReq = q.runReq;
   assign runAddr = q.runAddr;
   assign swResetReq = q.swResetReq;

   // ---------------------------------------------------------------
   // outgoing bytes
   // ---------------------------------------------------------------
   // the buffer absorbs a receiver stall so no reply byte is dropped
   sbpl_txbuf u_txbuf (
      .core_clk(core_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .inValid(q.pushV),
      .inData(q.pushD),
      .inReady(bufReady),
      .outValid(txValid), // R5
      .outData(txData),
      .outReady(txReady)
   );

   // ---------------------------------------------------------------
   // packet engine
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.flashWrReq = 1'b0;
      d.flashEraseReq = 1'b0;
      d.runReq = 1'b0;
      d.swResetReq = 1'b0;
      if (q.pushV && bufReady) begin
         d.pushV = 1'b0;
      end
      case (q.st)
         ST_IDLE: begin
            if (!q.locked) begin
               if (bValid && bData != ZERO_BYTE) begin
                  d.locked = 1'b1; // R24
                  d.onB = 1'b1;
                  d.len = bData; // R1
                  d.sum = ZERO_BYTE;
                  d.idx = ZERO_BYTE;
                  d.st = ST_SUM;
               end else if (aValid) begin
                  if (aData == SYNC_BYTE && q.syncSeen) begin
                     d.locked = 1'b1; // R24
                     d.onB = 1'b0;
                     d.exec = 1'b0;
                     d.ackByte = ACK_BYTE; // R23
                     d.st = ST_ACK;
                  end else begin
                     d.syncSeen = (aData == SYNC_BYTE); // R23
                  end
               end
            end else if (rxV && rxB != ZERO_BYTE) begin
               d.len = rxB; // R1
               d.sum = ZERO_BYTE;
               d.idx = ZERO_BYTE;
               d.st = ST_SUM;
            end
         end
         ST_SUM: begin
            if (rxV) begin
               d.rxSum = rxB; // R2
               d.st = (q.len < LEN_MIN) ? ST_CHECK : ST_PAY;
            end
         end
         ST_PAY: begin
            if (rxV) begin
               // oversize payloads are summed but not kept
               if (q.idx < PAY_DEPTH_B) begin
                  d.pay[q.idx[3:0]] = rxB;
               end
               d.sum = q.sum + rxB; // R25
               d.idx = q.idx + 8'h01;
               if (q.idx + LEN_MIN == q.len) begin // R1
                  d.st = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            d.ackByte = ACK_BYTE;
            d.exec = 1'b0;
            d.st = ST_ACK;
            if (q.len < LEN_MIN || q.len > LEN_MAX || q.sum != q.rxSum) begin
               d.ackByte = NAK_BYTE; // R3 R18 R25
            end else begin
               // command validity only lands in status, never in the ack
               case (cmd) // R4
                  CMD_PING: begin
                     d.status = (q.len == LEN_SHORT) ? STAT_SUCCESS
                                                     : STAT_INVALID; // R11
                  end
                  CMD_STATUS: begin
                     d.exec = 1'b1; // R12
                  end
                  CMD_DOWNLOAD: begin
                     d.dlActive = 1'b0;
                     if (q.len == LEN_DL && dlOk) begin
                        d.addr = pAddr; // R13
                        d.remain = pSize;
                        d.flashEraseReq = 1'b1; // R14
                        d.st = ST_ERASE;
                     end else begin
                        d.status = STAT_INVALID; // R14
                     end
                  end
                  CMD_SEND: begin
                     d.status = q.dlActive ? STAT_SUCCESS : STAT_INVALID; // R26
                     d.exec = q.dlActive;
                  end
                  CMD_RUN: begin
                     d.status = (q.len == LEN_RUN) ? STAT_SUCCESS : STAT_INVALID;
                     d.exec = (q.len == LEN_RUN);
                     d.runAddr = pAddr; // R20
                  end
                  CMD_RESET: begin
                     d.status = (q.len == LEN_SHORT) ? STAT_SUCCESS
                                                     : STAT_INVALID;
                     d.exec = (q.len == LEN_SHORT); // R21
                  end
                  default: begin
                     d.status = STAT_UNKNOWN; // R26
                  end
               endcase
            end
         end
         ST_ERASE: begin
            // the ack is held back until flashDone ends the erase, failed or not
            if (flashDone) begin
               d.status = flashErr ? STAT_FLASH_FAIL : STAT_SUCCESS; // R14
               d.dlActive = !flashErr;
               d.ackByte = ACK_BYTE;
               d.exec = 1'b0;
               d.st = ST_ACK;
            end
         end
         ST_ACK: begin
            if (!q.pushV) begin
               d.pushV = 1'b1;
               d.pushD = q.ackByte; // R3
               d.st = ST_IDLE;
               if (q.exec) begin
                  case (cmd)
                     CMD_STATUS: d.st = ST_RLEN;
                     CMD_SEND: begin
                        d.pIdx = PAY_DATA;
                        d.st = ST_PROG; // R15
                     end
                     CMD_RUN: d.st = ST_FIN;
                     CMD_RESET: d.st = ST_FIN;
                     default: d.st = ST_IDLE;
                  endcase
               end
            end
         end
         ST_PROG: begin
            if (q.remain == 32'h0000_0000) begin
               d.dlActive = 1'b0; // R17
               d.st = ST_IDLE;
            end else if ({4'h0, q.pIdx} + LEN_MIN > q.len) begin
               d.st = ST_IDLE;
            end else begin
               d.flashWrData = q.pay[q.pIdx];
               d.flashWrReq = 1'b1; // R15
               d.st = ST_WAITW;
            end
         end
         ST_WAITW: begin
            if (flashDone) begin
               if (flashErr) begin
                  d.status = STAT_FLASH_FAIL;
               end
               d.addr = q.addr + ADDR_STEP; // R15
               d.remain = q.remain - ADDR_STEP; // R17
               d.pIdx = q.pIdx + 4'h1;
               d.st = ST_PROG;
            end
         end
         ST_RLEN: begin
            if (!q.pushV) begin
               d.pushV = 1'b1;
               d.pushD = RESP_LEN; // R1 R12
               d.st = ST_RSUM;
            end
         end
         ST_RSUM: begin
            // a one-byte payload sums to itself
            if (!q.pushV) begin
               d.pushV = 1'b1;
               d.pushD = q.status; // R2 R6
               d.st = ST_RDAT;
            end
         end
         ST_RDAT: begin
            if (!q.pushV) begin
               d.pushV = 1'b1;
               d.pushD = q.status; // R12 R6
               d.st = ST_RWAIT;
            end
         end
         ST_RWAIT: begin
            // either reply closes the exchange; a rejecting host resends
            if (rxV && rxB != ZERO_BYTE) begin // R9
               d.st = ST_IDLE;
            end
         end
         ST_FIN: begin
            // wait until the ack has left the wire before acting
            if (!q.pushV && !txValid) begin
               d.runReq = (cmd == CMD_RUN); // R20
               d.swResetReq = (cmd == CMD_RESET); // R21
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.status <= STAT_SUCCESS;
      end else if (clkEn) begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn || !clkEn);

   property p_nakOnBadSum;
      q.st == ST_CHECK && q.len >= LEN_MIN && q.sum != q.rxSum
         |=> q.st == ST_ACK && q.ackByte == NAK_BYTE;
   endproperty
   a_nakOnBadSum: assert property (p_nakOnBadSum) // R3
      else $error("bad checksum not answered with nak");

   property p_ackBeforeRun;
      runReq |-> $past(q.st) == ST_FIN && !txValid;
   endproperty
   a_ackBeforeRun: assert property (p_ackBeforeRun) // R20
      else $error("jump issued before ack drained");

   property p_ackBeforeReset;
      swResetReq |-> $past(q.st, 2) == ST_FIN || $past(q.st) == ST_FIN;
   endproperty
   a_ackBeforeReset: assert property (p_ackBeforeReset) // R21
      else $error("reset issued outside the final step");

   property p_eraseHoldsAck;
      q.st == ST_ERASE && !flashDone |=> q.st == ST_ERASE && !q.pushV;
   endproperty
   a_eraseHoldsAck: assert property (p_eraseHoldsAck) // R14
      else $error("ack sent before erase finished");

   property p_addrAdvance;
      q.st == ST_WAITW && flashDone
         |=> q.addr == $past(q.addr) + ADDR_STEP && q.st == ST_PROG;
   endproperty
   a_addrAdvance: assert property (p_addrAdvance) // R15
      else $error("address did not advance by one");

   property p_nakKeepsAddr;
      q.st == ST_ACK && q.ackByte == NAK_BYTE
         |=> $stable(q.addr) ##1 $stable(q.addr);
   endproperty
   a_nakKeepsAddr: assert property (p_nakKeepsAddr) // R18
      else $error("address moved after nak");

   property p_sessionEnd;
      q.st == ST_PROG && q.remain == 32'h0000_0000 |=> !q.dlActive;
   endproperty
   a_sessionEnd: assert property (p_sessionEnd) // R17
      else $error("session still open after last byte");

   property p_lockHolds;
      q.locked |=> q.locked && q.onB == $past(q.onB);
   endproperty
   a_lockHolds: assert property (p_lockHolds) // R24
      else $error("link choice changed without reset");

   property p_zeroSkipped;
      q.st == ST_RWAIT && (!rxV || rxB == ZERO_BYTE) |=> q.st == ST_RWAIT;
   endproperty
   a_zeroSkipped: assert property (p_zeroSkipped) // R9
      else $error("zero byte taken as host reply");

   property p_respOrder;
      q.st == ST_RLEN && !q.pushV
         |=> q.pushD == RESP_LEN ##[1:4] q.pushV && q.pushD == q.status;
   endproperty
   a_respOrder: assert property (p_respOrder) // R12
      else $error("status packet out of order");

   c_ping: cover property (q.st == ST_CHECK && cmd == CMD_PING ##1 q.st == ST_ACK);
   c_status: cover property (q.st == ST_RWAIT ##[1:50] q.st == ST_IDLE);
   c_program: cover property (q.st == ST_WAITW && flashDone);
   c_stall: cover property (txValid && !txReady && !bufReady);

endmodule

// ==== hw/sbpl_pkg.sv ====
package sbpl_pkg;

   // ---------------------------------------------------------------
   // framing bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] ACK_BYTE = 8'hCC;
   localparam logic [7:0] NAK_BYTE = 8'h33;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // command codes and packet lengths
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_PING = 8'h20;
   localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
   localparam logic [7:0] CMD_RUN = 8'h22;
   localparam logic [7:0] CMD_STATUS = 8'h23;
   localparam logic [7:0] CMD_SEND = 8'h24;
   localparam logic [7:0] CMD_RESET = 8'h25;

   localparam logic [7:0] LEN_MIN = 8'h03;
   localparam logic [7:0] LEN_SHORT = 8'h03;
   localparam logic [7:0] LEN_RUN = 8'h07;
   localparam logic [7:0] LEN_DL = 8'h0B;
   localparam logic [7:0] LEN_MAX = 8'h0B;
   localparam logic [7:0] RESP_LEN = 8'h03;

   // ---------------------------------------------------------------
   // status codes (values are arbitrary)
   // ---------------------------------------------------------------
   localparam logic [7:0] STAT_SUCCESS = 8'h40;
   localparam logic [7:0] STAT_UNKNOWN = 8'h41;
   localparam logic [7:0] STAT_INVALID = 8'h42;
   localparam logic [7:0] STAT_FLASH_FAIL = 8'h43;

   // programmable area, bytes (plain default)
   localparam logic [32:0] FLASH_BYTES = 33'h0_0004_0000;

   // ---------------------------------------------------------------
   // payload store layout
   // ---------------------------------------------------------------
   localparam int PAY_DEPTH = 9;
   localparam logic [7:0] PAY_DEPTH_B = 8'h09;
   localparam logic [3:0] PAY_CMD = 4'h0;
   localparam logic [3:0] PAY_ADDR = 4'h1;
   localparam logic [3:0] PAY_SIZE = 4'h5;
   localparam logic [3:0] PAY_DATA = 4'h1;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0001;

   localparam int BUF_W = 8;

   typedef enum logic [12:0] {
      ST_IDLE = 13'h0001,
      ST_SUM = 13'h0002,
      ST_PAY = 13'h0004,
      ST_CHECK = 13'h0008,
      ST_ERASE = 13'h0010,
      ST_ACK = 13'h0020,
      ST_PROG = 13'h0040,
      ST_WAITW = 13'h0080,
      ST_RLEN = 13'h0100,
      ST_RSUM = 13'h0200,
      ST_RDAT = 13'h0400,
      ST_RWAIT = 13'h0800,
      ST_FIN = 13'h1000
   } sbpl_state_t;

   typedef struct packed {
      sbpl_state_t st;
      logic locked;
      logic onB;
      logic syncSeen;
      logic exec;
      logic dlActive;
      logic pushV;
      logic flashWrReq;
      logic flashEraseReq;
      logic runReq;
      logic swResetReq;
      logic [7:0] len;
      logic [7:0] idx;
      logic [7:0] sum;
      logic [7:0] rxSum;
      logic [7:0] ackByte;
      logic [7:0] status;
      logic [7:0] pushD;
      logic [7:0] flashWrData;
      logic [3:0] pIdx;
      logic [PAY_DEPTH-1:0][7:0] pay;
      logic [31:0] addr;
      logic [31:0] remain;
      logic [31:0] runAddr;
   } sbpl_core_t;

   typedef struct packed {
      logic hV;
      logic [BUF_W-1:0] hD;
      logic tV;
      logic [BUF_W-1:0] tD;
   } sbpl_buf_t;

endpackage

// ==== hw/sbpl_txbuf.sv ====
module sbpl_txbuf
   import sbpl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic inValid,
   input wire logic [BUF_W-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [BUF_W-1:0] outData,
   input wire logic outReady
);

   // head feeds the output straight from its register; tail catches
   // the word that arrives while the receiver stalls
   sbpl_buf_t q;
   sbpl_buf_t d;
   logic pop;
   logic push;

   assign inReady = !q.tV;
   assign outValid = q.hV;
   assign outData = q.hD;

   always_comb begin
      d = q;
      pop = q.hV && outReady;
      push = inValid && !q.tV;
      if (pop) begin
         d.hV = q.tV || push;
         d.hD = q.tV ? q.tD : inData;
         d.tV = q.tV && push;
         d.tD = inData;
      end else if (push) begin
         if (!q.hV) begin
            d.hV = 1'b1;
            d.hD = inData;
         end else begin
            d.tV = 1'b1;
            d.tD = inData;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

endmodule
